// ---- hw/flk_cmd_handler.sv ----
/*
  flk_cmd_handler: protect (lock) and user configuration bit commands of
  the parallel flash programming port, with the stored bits themselves.
  assumes: pins arrive asynchronously and are held stable by the
  programmer while the command strobe is low; page programming logic on
  the same clock reports page-and-protect commands by a one-cycle pulse.
*/
// Function
// - protect bits are also set by the write-page-and-protect commands.
// - set-protect activates every protect bit selected by the mask.
// - mask bit n acts on protect bit n, bit 0 on the first one.
// - clear-protect clears every protect bit selected by the mask.
// - erase-all clears every protect bit as well as the array.
// - set/clear-protect are a command-phase write then a data-phase write.
// - read-protect is a command-phase write then a data-phase read.
// - the returned mask has bit n high exactly when protect bit n is set.
// - set-user-bit activates each user bit selected, bit 0 the first.
// - clear-user-bit clears each user bit whose pattern bit is one.
// - erase-all also clears every user configuration bit.
// - set/clear-user-bit are a command-phase then a data-phase write.
// - erase-all aborts and erases nothing while any protect bit is set.
`timescale 1ns/1ps
module flk_cmd_handler #(
  parameter int unsigned NUM_PROTECT = flk_pkg::NUM_PROTECT_DEF,
  parameter int unsigned NUM_USER    = flk_pkg::NUM_USER_DEF
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       pgm_cmd_n,
  input  wire logic                       pgm_oe_n,
  input  wire logic [flk_pkg::MODE_W-1:0] pgm_mode,
  input  wire logic [flk_pkg::DATA_W-1:0] pgm_data_i,
  output logic      [flk_pkg::DATA_W-1:0] pgm_data_o,
  output logic                            pgm_data_oe,
  output logic                            pgm_rdy,
  output logic                            pgm_valid_n,
  input  wire logic                       page_protect_set,
  input  wire logic [$clog2(NUM_PROTECT)-1:0] page_protect_idx,
  output logic      [NUM_PROTECT-1:0]     protect_bits,
  output logic      [NUM_USER-1:0]        user_config_bits,
  output logic                            erase_all_go,
  output logic                            erase_abort
);

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (NUM_PROTECT < 2 || NUM_PROTECT > flk_pkg::DATA_W) begin : g_chk_p
    $error("NUM_PROTECT must lie between 2 and the data width");
  end
  if (NUM_USER < 1 || NUM_USER > flk_pkg::DATA_W) begin : g_chk_u
    $error("NUM_USER must lie between 1 and the data width");
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [NUM_PROTECT-1:0] protect_mask(
    input logic [flk_pkg::DATA_W-1:0] d);
    protect_mask = d[NUM_PROTECT-1:0];
  endfunction

  function automatic logic [NUM_USER-1:0] user_mask(
    input logic [flk_pkg::DATA_W-1:0] d);
    user_mask = d[NUM_USER-1:0];
  endfunction

  // ----------------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------------
  flk_pkg::flk_pins_s meta_q;
  flk_pkg::flk_pins_s pins_q;
  flk_pkg::flk_pins_s pins_raw;

  always_comb begin
    pins_raw.cmd_n = pgm_cmd_n;
    pins_raw.oe_n  = pgm_oe_n;
    pins_raw.mode  = pgm_mode;
    pins_raw.data  = pgm_data_i;
  end

  // bus is held stable while the strobe is low, so a word-wide
  // two-stage sample cannot tear once the strobe is seen
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '{cmd_n: 1'b1, oe_n: 1'b1, mode: '0, data: '0};
      pins_q <= '{cmd_n: 1'b1, oe_n: 1'b1, mode: '0, data: '0};
    end else begin
      meta_q <= pins_raw;
      pins_q <= meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // handshake sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_READ,
    ST_RELEASE
  } flk_state_e;

  flk_state_e                    state_q, state_d;
  flk_pkg::flk_cmd_e             pend_q, pend_d;
  logic [flk_pkg::DATA_W-1:0]    word_q, word_d;
  logic [NUM_PROTECT-1:0]        prot_q, prot_d;
  logic [NUM_USER-1:0]           user_q, user_d;
  logic [flk_pkg::DATA_W-1:0]    dout_q, dout_d;
  logic                          doe_q, doe_d;
  logic                          rdy_q, rdy_d;
  logic                          valid_n_q, valid_n_d;
  logic                          go_q, go_d;
  logic                          abort_q, abort_d;
  logic                          is_cmd, is_data;

  always_comb begin
    is_cmd  = pins_q.mode == flk_pkg::MODE_COMMAND_PHASE;
    is_data = pins_q.mode == flk_pkg::MODE_DATA_PHASE;
  end

  always_comb begin
    state_d   = state_q;
    pend_d    = pend_q;
    word_d    = word_q;
    prot_d    = prot_q;
    user_d    = user_q;
    dout_d    = dout_q;
    doe_d     = doe_q;
    rdy_d     = rdy_q;
    valid_n_d = valid_n_q;
    go_d      = 1'b0;
    abort_d   = abort_q;

    unique case (state_q)
      ST_IDLE: begin
        // ready stays high here; a strobe is a new handshake
        if (!pins_q.cmd_n) begin
          word_d = pins_q.data;
          rdy_d  = 1'b0;
          if (!pins_q.oe_n) begin
            state_d = ST_READ;
          end else begin
            state_d = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        state_d = ST_RELEASE;
        rdy_d   = 1'b1;
        if (is_cmd) begin
          unique case (word_q)
            flk_pkg::OP_SET_PROTECT:    pend_d = flk_pkg::FLK_CMD_SET_PROTECT;
            flk_pkg::OP_CLEAR_PROTECT:  pend_d = flk_pkg::FLK_CMD_CLEAR_PROTECT;
            flk_pkg::OP_READ_PROTECT:   pend_d = flk_pkg::FLK_CMD_READ_PROTECT;
            flk_pkg::OP_SET_USER_BIT:   pend_d = flk_pkg::FLK_CMD_SET_USER;
            flk_pkg::OP_CLEAR_USER_BIT: pend_d = flk_pkg::FLK_CMD_CLEAR_USER;
            flk_pkg::OP_ERASE_ALL:      pend_d = flk_pkg::FLK_CMD_ERASE_ALL;
            default:                    pend_d = flk_pkg::FLK_CMD_NONE;
          endcase
        end else if (is_data) begin
          pend_d = flk_pkg::FLK_CMD_NONE;
          unique case (pend_q)
            flk_pkg::FLK_CMD_SET_PROTECT: begin
              prot_d = prot_d | protect_mask(word_q);
            end
            flk_pkg::FLK_CMD_CLEAR_PROTECT: begin
              prot_d = prot_d & ~protect_mask(word_q);
            end
            flk_pkg::FLK_CMD_SET_USER: begin
              user_d = user_q | user_mask(word_q);
            end
            flk_pkg::FLK_CMD_CLEAR_USER: begin
              user_d = user_q & ~user_mask(word_q);
            end
            flk_pkg::FLK_CMD_ERASE_ALL: begin
              // a protected region blocks the whole erase
              if (|prot_q) begin
                abort_d = 1'b1;
              end else begin
                abort_d = 1'b0;
                go_d    = 1'b1;
                prot_d  = '0;
                user_d  = '0;
              end
            end
            default: begin
            end
          endcase
        end else begin
          // unknown mode drops any half-finished command
          pend_d = flk_pkg::FLK_CMD_NONE;
        end
      end
      ST_READ: begin
        // only a read of a pending read-protect returns status
        if (is_data && pend_q == flk_pkg::FLK_CMD_READ_PROTECT) begin
          dout_d = flk_pkg::DATA_W'(prot_q);
        end else begin
          dout_d = '0;
        end
        pend_d    = flk_pkg::FLK_CMD_NONE;
        doe_d     = 1'b1;
        valid_n_d = 1'b0;
        rdy_d     = 1'b1;
        state_d   = ST_RELEASE;
      end
      ST_RELEASE: begin
        // data bus is freed only when the programmer ends the strobe
        if (pins_q.cmd_n) begin
          doe_d     = 1'b0;
          valid_n_d = 1'b1;
          state_d   = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase

    // applied last so a page pulse wins over a clear or erase in one cycle
    if (page_protect_set) begin
      prot_d[page_protect_idx] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      pend_q    <= flk_pkg::FLK_CMD_NONE;
      word_q    <= '0;
      prot_q    <= flk_pkg::PROTECT_RESET[NUM_PROTECT-1:0];
      user_q    <= flk_pkg::USER_BIT_RESET[NUM_USER-1:0];
      dout_q    <= '0;
      doe_q     <= 1'b0;
      rdy_q     <= 1'b1;
      valid_n_q <= 1'b1;
      go_q      <= 1'b0;
      abort_q   <= 1'b0;
    end else begin
      state_q   <= state_d;
      pend_q    <= pend_d;
      word_q    <= word_d;
      prot_q    <= prot_d;
      user_q    <= user_d;
      dout_q    <= dout_d;
      doe_q     <= doe_d;
      rdy_q     <= rdy_d;
      valid_n_q <= valid_n_d;
      go_q      <= go_d;
      abort_q   <= abort_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign pgm_data_o       = dout_q;
  assign pgm_data_oe      = doe_q;
  assign pgm_rdy          = rdy_q;
  assign pgm_valid_n      = valid_n_q;
  assign protect_bits     = prot_q;
  assign user_config_bits = user_q;
  assign erase_all_go     = go_q;
  assign erase_abort      = abort_q;

endmodule // flk_cmd_handler

// ---- hw/flk_pkg.sv ----
/*
  flk_pkg: constants and carrier types for the lock and user-bit command
  handler of the parallel flash programming port.
  assumes: one 200 MHz clock, synchronous active-high reset.
*/
package flk_pkg;

  // ----------------------------------------------------------------------
  // port widths
  // ----------------------------------------------------------------------
  localparam int unsigned DATA_W = 16;
  localparam int unsigned MODE_W = 4;

  // ----------------------------------------------------------------------
  // mode codes on the mode pins
  // ----------------------------------------------------------------------
  localparam logic [MODE_W-1:0] MODE_COMMAND_PHASE = 4'h5;
  localparam logic [MODE_W-1:0] MODE_DATA_PHASE    = 4'h7;

  // ----------------------------------------------------------------------
  // opcodes carried on the data pins in command phase
  // ----------------------------------------------------------------------
  localparam logic [DATA_W-1:0] OP_SET_PROTECT    = 16'h0001;
  localparam logic [DATA_W-1:0] OP_CLEAR_PROTECT  = 16'h0002;
  localparam logic [DATA_W-1:0] OP_READ_PROTECT   = 16'h0003;
  localparam logic [DATA_W-1:0] OP_SET_USER_BIT   = 16'h0004;
  localparam logic [DATA_W-1:0] OP_CLEAR_USER_BIT = 16'h0005;
  localparam logic [DATA_W-1:0] OP_ERASE_ALL      = 16'h0006;

  // ----------------------------------------------------------------------
  // reset values of the stored bits and default counts
  // ----------------------------------------------------------------------
  localparam logic [DATA_W-1:0] PROTECT_RESET   = 16'h0000;
  localparam logic [DATA_W-1:0] USER_BIT_RESET  = 16'h0000;
  localparam int unsigned       NUM_PROTECT_DEF = 16;
  localparam int unsigned       NUM_USER_DEF    = 4;

  typedef enum logic [2:0] {
    FLK_CMD_NONE,
    FLK_CMD_SET_PROTECT,
    FLK_CMD_CLEAR_PROTECT,
    FLK_CMD_READ_PROTECT,
    FLK_CMD_SET_USER,
    FLK_CMD_CLEAR_USER,
    FLK_CMD_ERASE_ALL
  } flk_cmd_e;

  // sampled programming pins, moved as one word through the synchroniser
  typedef struct packed {
    logic              cmd_n;
    logic              oe_n;
    logic [MODE_W-1:0] mode;
    logic [DATA_W-1:0] data;
  } flk_pins_s;

endpackage : flk_pkg

// ---- tb/flk_cmd_handler_asserts.sv ----
/* flk_cmd_asserts: port checks for the protect and user bit handler.
   assumes: bound to flk_cmd_handler; one clock, synchronous reset. */
`timescale 1ns/1ps
module flk_cmd_asserts #(
  parameter int unsigned NUM_PROTECT = 16,
  parameter int unsigned NUM_USER    = 4
) (
  input wire logic                           clk,
  input wire logic                           rst,
  input wire logic                           pgm_cmd_n,
  input wire logic                           pgm_oe_n,
  input wire logic [15:0]                    pgm_data_o,
  input wire logic                           pgm_data_oe,
  input wire logic                           pgm_rdy,
  input wire logic                           pgm_valid_n,
  input wire logic                           page_protect_set,
  input wire logic [$clog2(NUM_PROTECT)-1:0] page_protect_idx,
  input wire logic [NUM_PROTECT-1:0]         protect_bits,
  input wire logic [NUM_USER-1:0]            user_config_bits,
  input wire logic                           erase_all_go,
  input wire logic                           erase_abort
);
  // ----------------------------------------
  // handshake and stored bit checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence answer_s;
    pgm_rdy ##3 !pgm_rdy ##1 pgm_rdy;
  endsequence
  sequence read_on_s;
    ##4 !pgm_valid_n && pgm_data_oe;
  endsequence
  sequence read_off_s;
    !pgm_valid_n [*3] ##1 pgm_valid_n && !pgm_data_oe;
  endsequence
  rdy_answer_a: assert property ($fell(pgm_cmd_n) |-> answer_s)
    else $error("ready answer out of step");
  read_drive_a: assert property ($fell(pgm_cmd_n) && !pgm_oe_n |-> read_on_s)
    else $error("read data not driven in time");
  read_release_a: assert property ($rose(pgm_cmd_n) && !pgm_valid_n |-> read_off_s)
    else $error("read data not released in time");
  oe_valid_a: assert property (pgm_data_oe == !pgm_valid_n)
    else $error("drive enable and valid disagree");
  read_upper_a: assert property (pgm_data_oe |-> (pgm_data_o >> NUM_PROTECT) == '0)
    else $error("unimplemented mask bits read nonzero");
  erase_pulse_a: assert property (erase_all_go |=> !erase_all_go)
    else $error("erase start longer than one cycle");
  erase_locked_a: assert property (erase_all_go |-> $past(protect_bits) == '0)
    else $error("erase started while protected");
  erase_clear_a: assert property (erase_all_go |-> ##[0:1] (protect_bits == '0 && user_config_bits == '0))
    else $error("erase left bits set");
  abort_flag_a: assert property ($rose(erase_abort) |-> protect_bits != '0)
    else $error("erase refused with no protect bit set");
  page_set_a: assert property (page_protect_set && pgm_cmd_n |=> protect_bits[$past(page_protect_idx)])
    else $error("page protect did not set its bit");
endmodule // flk_cmd_asserts

bind flk_cmd_handler flk_cmd_asserts #(
  .NUM_PROTECT(NUM_PROTECT), .NUM_USER(NUM_USER)
) u_asserts (
  .clk, .rst, .pgm_cmd_n, .pgm_oe_n, .pgm_data_o, .pgm_data_oe, .pgm_rdy,
  .pgm_valid_n, .page_protect_set, .page_protect_idx, .protect_bits,
  .user_config_bits, .erase_all_go, .erase_abort
);

// ---- tb/flk_prog_model.sv ----
/* flk_prog_model: external programmer on the parallel handshake port.
   assumes: pins change on the falling clock edge, rdy is registered. */
`timescale 1ns/1ps
module flk_prog_model (
  input  wire logic        clk,
  output logic             cmd_n,
  output logic             oe_n,
  output logic [3:0]       mode,
  output logic [15:0]      data,
  input  wire logic        rdy,
  input  wire logic        valid_n,
  input  wire logic [15:0] rdata
);
  int unsigned late = 0;
  initial begin
    cmd_n = 1'b1;
    oe_n = 1'b1;
    mode = 4'h0;
    data = 16'h0000;
  end
  // one handshake; dly stretches the strobe to act as a slow programmer
  task automatic xfer(input logic rd, input logic [3:0] m,
                      input logic [15:0] d, input int dly,
                      output logic [15:0] q);
    int n;
    n = 0;
    @(negedge clk);
    mode = m;
    data = d;
    oe_n = ~rd;
    @(negedge clk);
    cmd_n = 1'b0;
    while (rdy && n < 8) begin
      @(negedge clk);
      n++;
    end
    while (!rdy && n < 16) begin
      @(negedge clk);
      n++;
    end
    q = rdata;
    if (n >= 8 || (rd && valid_n)) late++;
    repeat (dly) @(negedge clk);
    cmd_n = 1'b1;
    oe_n = 1'b1;
    // released pins must not keep showing the last value
    data = ~data;
    repeat (4) @(negedge clk);
  endtask
endmodule // flk_prog_model

// ---- tb/tb_top.sv ----
/* tb_top: table-driven bench for the protect and user bit handler.
   assumes: flk_prog_model plays the programmer; checker is bound. */
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [15:0] op;
    logic [15:0] mask;
    logic [15:0] prot;
    logic [15:0] user;
    logic        abort;
  } flk_row_s;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cmd_n, oe_n, rdy, vld_n, doe, go, abort;
  logic        pp_set = 1'b0;
  logic [2:0]  pp_idx = 3'h0;
  logic [3:0]  mode, user;
  logic [7:0]  prot;
  logic [15:0] din, dout, q;
  int unsigned failures = 0;
  int unsigned tests_run = 0;
  int unsigned cycles = 0;
  int unsigned go_seen = 0;
  flk_row_s rows [9] = '{
    '{flk_pkg::OP_SET_PROTECT, 16'h0081, 16'h0081, 16'h0000, 1'b0},
    '{flk_pkg::OP_SET_PROTECT, 16'hff02, 16'h0083, 16'h0000, 1'b0},
    '{flk_pkg::OP_CLEAR_PROTECT, 16'h0080, 16'h0003, 16'h0000, 1'b0},
    '{flk_pkg::OP_SET_USER_BIT, 16'h0009, 16'h0003, 16'h0009, 1'b0},
    '{flk_pkg::OP_SET_USER_BIT, 16'hfff2, 16'h0003, 16'h000b, 1'b0},
    '{flk_pkg::OP_CLEAR_USER_BIT, 16'h0001, 16'h0003, 16'h000a, 1'b0},
    '{flk_pkg::OP_ERASE_ALL, 16'h0000, 16'h0003, 16'h000a, 1'b1},
    '{flk_pkg::OP_CLEAR_PROTECT, 16'hffff, 16'h0000, 16'h000a, 1'b1},
    '{flk_pkg::OP_ERASE_ALL, 16'h0000, 16'h0000, 16'h0000, 1'b0}};

  always #2.5 clk = ~clk;
  flk_cmd_handler #(.NUM_PROTECT(8), .NUM_USER(4)) DUT (
    .clk, .rst, .pgm_cmd_n(cmd_n), .pgm_oe_n(oe_n), .pgm_mode(mode),
    .pgm_data_i(din), .pgm_data_o(dout), .pgm_data_oe(doe),
    .pgm_rdy(rdy), .pgm_valid_n(vld_n), .page_protect_set(pp_set),
    .page_protect_idx(pp_idx), .protect_bits(prot),
    .user_config_bits(user), .erase_all_go(go), .erase_abort(abort));
  flk_prog_model prog (.clk, .cmd_n, .oe_n, .mode, .data(din), .rdy,
    .valid_n(vld_n), .rdata(dout));

  // ----------------------------------------
  // compare and handshake helpers
  // ----------------------------------------
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [15:0] op, input logic [15:0] mask);
    prog.xfer(1'b0, flk_pkg::MODE_COMMAND_PHASE, op, 0, q);
    prog.xfer(1'b0, flk_pkg::MODE_DATA_PHASE, mask, 0, q);
  endtask
  task automatic rd(input logic [15:0] op, input int dly);
    prog.xfer(1'b0, flk_pkg::MODE_COMMAND_PHASE, op, 0, q);
    prog.xfer(1'b1, flk_pkg::MODE_DATA_PHASE, 16'h0000, dly, q);
  endtask
  task automatic do_reset;
    rst = 1'b1;
    repeat (8) @(negedge clk);
    chk_bit(rdy & vld_n & ~doe & ~go & ~abort, 1'b1);
    chk_val({prot, 4'h0, user}, 16'h0000);
    rst = 1'b0;
  endtask
  task automatic end_of_test;
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (go) go_seen++;
    if (cycles == 3000) begin
      failures++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    do_reset();
    foreach (rows[i]) begin
      cmd(rows[i].op, rows[i].mask);
      chk_val(16'(prot), rows[i].prot);
      chk_val(16'(user), rows[i].user);
      chk_bit(abort, rows[i].abort);
      rd(flk_pkg::OP_READ_PROTECT, i % 3);
      chk_val(q, rows[i].prot);
    end
    @(negedge clk);
    pp_set = 1'b1;
    pp_idx = 3'h6;
    @(negedge clk);
    pp_set = 1'b0;
    @(negedge clk);
    chk_val(16'(prot), 16'h0040);
    // a second command phase replaces the pending opcode
    prog.xfer(1'b0, flk_pkg::MODE_COMMAND_PHASE,
              flk_pkg::OP_SET_PROTECT, 0, q);
    cmd(flk_pkg::OP_CLEAR_PROTECT, 16'h0040);
    chk_val(16'(prot), 16'h0000);
    prog.xfer(1'b0, flk_pkg::MODE_COMMAND_PHASE,
              flk_pkg::OP_SET_PROTECT, 0, q);
    cmd(16'h00ff, 16'hffff);
    chk_val(16'(prot), 16'h0000);
    rd(16'h00ff, 0);
    chk_val(q, 16'h0000);
    cmd(flk_pkg::OP_SET_USER_BIT, 16'h000f);
    chk_val(16'(user), 16'h000f);
    chk_val(16'(go_seen), 16'h0001);
    do_reset();
    chk_val(16'(prog.late), 16'h0000);
    end_of_test();
  end
endmodule // tb_top
